// ===== design/bir_params.svh
`ifndef BIR_PARAMS_SVH
`define BIR_PARAMS_SVH
`define BIR_ADDR_W 8
`define BIR_OFF_CTRL 8'h00
`define BIR_OFF_CMD 8'h04
`define BIR_OFF_STATUS 8'h08
`define BIR_OFF_SCREEN 8'h0C
`define BIR_OFF_TABLE 8'h40
`define BIR_TABLE_DEPTH 16
`define BIR_CTRL_MODE_LO 0
`define BIR_CTRL_MODE_HI 1
`define BIR_CTRL_IDLE_LO 2
`define BIR_CTRL_IDLE_HI 3
`define BIR_CTRL_RESUME 4
`define BIR_CTRL_CHECK 5
`define BIR_CMD_BUZZ_SEL 0
`define BIR_CMD_IDLE_SEL 1
`define BIR_CMD_RESUME_SEL 2
`define BIR_CMD_HOST_START 3
`define BIR_CMD_PAT_LO 4
`define BIR_CMD_PAT_HI 6
`define BIR_CMD_HOST_STOP 7
`define BIR_CMD_SCREEN 8
`define BIR_CMD_INIT_TABLE 9
`define BIR_CMD_PRINT 10
`define BIR_ST_BUZZER 0
`define BIR_ST_BLANKED 1
`define BIR_ST_HOST 2
`define BIR_ST_ATTR 3
`define BIR_ST_ERR 4
`define BIR_ST_REFUSED 5
`define BIR_ST_WB_BUSY 6
`define BIR_RESP_OKAY 2'h0
`define BIR_RESP_SLVERR 2'h2
`define BIR_CLK_HZ 250000000
`define BIR_SHORT_MS 500
`define BIR_LONG_MS 1000
`define BIR_IDLE_SHORT_S 600
`define BIR_IDLE_LONG_S 3600
`define BIR_RESUME_RST 1'h0
`endif

// ===== design/bir_pkg.sv
package bir_pkg;
	typedef enum logic [1:0] {BM_ON, BM_ERR_ON, BM_OFF} bir_buzz_mode_type;
	typedef enum logic [1:0] {IT_10MIN, IT_1HOUR, IT_NONE} bir_idle_type;
	typedef enum logic [1:0] {TONE_CONT, TONE_SHORT, TONE_LONG} bir_tone_type;
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} bir_axi_req_type;
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bir_axi_rsp_type;
endpackage

// ===== design/bir_buzzer_idle_resume.sv
`timescale 1ns/10ps
`default_nettype none
`include "bir_params.svh"
module bir_buzzer_idle_resume
	import bir_pkg::*;
#(
	parameter int TABLE_DEPTH = `BIR_TABLE_DEPTH,
	parameter logic [31:0] SHORT_CYC = 32'(`BIR_CLK_HZ / 1000 * `BIR_SHORT_MS),
	parameter logic [31:0] LONG_CYC = 32'(`BIR_CLK_HZ / 1000 * `BIR_LONG_MS),
	parameter logic [39:0] IDLE_SHORT_CYC = 40'(64'(`BIR_CLK_HZ) * `BIR_IDLE_SHORT_S),
	parameter logic [39:0] IDLE_LONG_CYC = 40'(64'(`BIR_CLK_HZ) * `BIR_IDLE_LONG_S),
	parameter bit COLOUR_MODEL = 1'b1
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire bir_axi_req_type axi_req,
	output bir_axi_rsp_type axi_rsp,
	input wire logic err_event,
	input wire logic screen_change,
	input wire logic screen_buzz_attr,
	input wire logic [2:0] screen_pattern,
	input wire logic touch_press,
	input wire logic touch_stop_press,
	input wire logic popup_active,
	input wire logic term_restart,
	input wire logic run_entry,
	input wire logic wb_ready,
	output logic buzzer,
	output logic display_on,
	output logic backlight_on,
	output logic redisplay_req,
	output logic print_start,
	output logic wb_valid,
	output logic [$clog2(TABLE_DEPTH)-1:0] wb_index,
	output logic [31:0] wb_data
);
	localparam int IW = $clog2(TABLE_DEPTH);
	localparam logic [`BIR_ADDR_W-1:0] TABLE_END = `BIR_ADDR_W'(`BIR_OFF_TABLE + 4 * TABLE_DEPTH);

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		bir_axi_rsp_type rsp;
		bir_buzz_mode_type mode;
		bir_idle_type idle;
		logic resume;
		logic check;
		logic host_req;
		bir_tone_type host_tone;
		logic attr_req;
		bir_tone_type attr_tone;
		logic err_req;
		bir_tone_type tone;
		logic phase;
		logic [31:0] tone_cnt;
		logic [39:0] idle_cnt;
		logic disp_on;
		logic bl_on;
		logic scr_attr;
		logic active;
		logic [31:0] screen;
		logic refused;
		logic wb_busy;
		logic wb_valid;
		logic [IW-1:0] wb_idx;
		logic [31:0] wb_data;
		logic [TABLE_DEPTH-1:0][31:0] table_mem;
		logic buzzer;
		logic redisplay;
		logic print_go;
	} bir_state_type;

	bir_state_type s;
	bir_state_type next_s;

	function automatic bir_tone_type pick_tone(input logic [2:0] req);
		if (req[0])
			return TONE_CONT;
		else if (req[1])
			return TONE_SHORT;
		else
			return TONE_LONG;
	endfunction

	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	always_comb
	begin
		logic [31:0] cmd;
		logic [31:0] mask;
		logic [IW-1:0] widx;
		logic [IW-1:0] ridx;
		logic stop_all;
		logic attr_take;
		logic want;
		logic [31:0] interval;
		logic [39:0] idle_limit;
		logic restore;
		logic restart;
		bir_tone_type sel;
		logic start_wb;
		logic clear_tbl;
		cmd = '0;
		sel = TONE_CONT;
		start_wb = 1'b0;
		clear_tbl = 1'b0;
		mask = '0;
		widx = '0;
		ridx = '0;
		stop_all = 1'b0;
		attr_take = 1'b0;
		want = 1'b0;
		interval = '0;
		idle_limit = '0;
		restore = 1'b0;
		restart = 1'b0;
		next_s = s;
		next_s.redisplay = 1'b0;
		next_s.print_go = 1'b0;

		// write channel: address and data may arrive in either order
		if (s.rsp.bvalid && axi_req.bready)
			next_s.rsp.bvalid = 1'b0;
		if (axi_req.awvalid && s.rsp.awready)
		begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && s.rsp.wready)
		begin
			next_s.w_got = 1'b1;
			next_s.wdata = axi_req.wdata;
			next_s.wstrb = axi_req.wstrb;
		end
		if (next_s.aw_got && next_s.w_got && !next_s.rsp.bvalid)
		begin
			mask = lane_mask(next_s.wstrb);
			widx = next_s.awaddr[IW+1:2];
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.rsp.bvalid = 1'b1;
			next_s.rsp.bresp = `BIR_RESP_OKAY;
			if (next_s.awaddr == `BIR_OFF_CTRL)
			begin
				if (next_s.wstrb[0])
				begin
					next_s.mode = bir_buzz_mode_type'(next_s.wdata[`BIR_CTRL_MODE_HI:`BIR_CTRL_MODE_LO]);
					next_s.idle = bir_idle_type'(next_s.wdata[`BIR_CTRL_IDLE_HI:`BIR_CTRL_IDLE_LO]);
					next_s.resume = next_s.wdata[`BIR_CTRL_RESUME];
					next_s.check = next_s.wdata[`BIR_CTRL_CHECK];
				end
			end
			else if (next_s.awaddr == `BIR_OFF_CMD)
				cmd = next_s.wdata & mask;
			else if (next_s.awaddr == `BIR_OFF_STATUS)
			begin
				if (next_s.wstrb[0] && next_s.wdata[`BIR_ST_REFUSED])
					next_s.refused = 1'b0;
			end
			else if (next_s.awaddr == `BIR_OFF_SCREEN)
				next_s.screen = (s.screen & ~mask) | (next_s.wdata & mask);
			else if (next_s.awaddr >= `BIR_OFF_TABLE && next_s.awaddr < TABLE_END && next_s.awaddr[1:0] == 2'h0)
				next_s.table_mem[widx] = (s.table_mem[widx] & ~mask) | (next_s.wdata & mask);
			else
				next_s.rsp.bresp = `BIR_RESP_SLVERR;
		end
		next_s.rsp.awready = !next_s.aw_got && !next_s.rsp.bvalid;
		next_s.rsp.wready = !next_s.w_got && !next_s.rsp.bvalid;

		// read channel: rdata is registered, so it stands until rready
		if (s.rsp.rvalid && axi_req.rready)
			next_s.rsp.rvalid = 1'b0;
		if (axi_req.arvalid && s.rsp.arready)
		begin
			ridx = axi_req.araddr[IW+1:2];
			next_s.rsp.rvalid = 1'b1;
			next_s.rsp.rresp = `BIR_RESP_OKAY;
			next_s.rsp.rdata = '0;
			if (axi_req.araddr == `BIR_OFF_CTRL)
			begin
				next_s.rsp.rdata[`BIR_CTRL_MODE_HI:`BIR_CTRL_MODE_LO] = s.mode;
				next_s.rsp.rdata[`BIR_CTRL_IDLE_HI:`BIR_CTRL_IDLE_LO] = s.idle;
				next_s.rsp.rdata[`BIR_CTRL_RESUME] = s.resume;
				next_s.rsp.rdata[`BIR_CTRL_CHECK] = s.check;
			end
			else if (axi_req.araddr == `BIR_OFF_STATUS)
			begin
				next_s.rsp.rdata[`BIR_ST_BUZZER] = s.buzzer;
				next_s.rsp.rdata[`BIR_ST_BLANKED] = !s.disp_on;
				next_s.rsp.rdata[`BIR_ST_HOST] = s.host_req;
				next_s.rsp.rdata[`BIR_ST_ATTR] = s.attr_req;
				next_s.rsp.rdata[`BIR_ST_ERR] = s.err_req;
				next_s.rsp.rdata[`BIR_ST_REFUSED] = s.refused;
				next_s.rsp.rdata[`BIR_ST_WB_BUSY] = s.wb_busy;
			end
			else if (axi_req.araddr == `BIR_OFF_SCREEN)
				next_s.rsp.rdata = s.screen;
			else if (axi_req.araddr >= `BIR_OFF_TABLE && axi_req.araddr < TABLE_END && axi_req.araddr[1:0] == 2'h0)
				next_s.rsp.rdata = s.table_mem[ridx];
			else if (axi_req.araddr != `BIR_OFF_CMD)
				next_s.rsp.rresp = `BIR_RESP_SLVERR;
		end
		next_s.rsp.arready = !next_s.rsp.rvalid;
		if (cmd[`BIR_CMD_BUZZ_SEL])
			next_s.mode = (s.mode == BM_ON) ? BM_ERR_ON : ((s.mode == BM_ERR_ON) ? BM_OFF : BM_ON);
		if (cmd[`BIR_CMD_IDLE_SEL])
			next_s.idle = (s.idle == IT_10MIN) ? IT_1HOUR : ((s.idle == IT_1HOUR) ? IT_NONE : IT_10MIN);
		if (cmd[`BIR_CMD_RESUME_SEL])
			next_s.resume = !s.resume;
		// requests: clears first, so a set in the same cycle wins
		stop_all = cmd[`BIR_CMD_HOST_STOP] || (screen_change && !screen_buzz_attr);
		stop_all = stop_all || (touch_stop_press && s.scr_attr);
		next_s.host_req = s.host_req && !stop_all;
		next_s.attr_req = s.attr_req && !stop_all;
		next_s.err_req = s.err_req && !stop_all;
		next_s.scr_attr = screen_change ? screen_buzz_attr : s.scr_attr;
		// a host command in the same cycle wins over the new screen's attribute
		attr_take = screen_change && screen_buzz_attr && !cmd[`BIR_CMD_HOST_START] && !cmd[`BIR_CMD_HOST_STOP];
		if (attr_take)
		begin
			next_s.attr_req = 1'b1;
			next_s.attr_tone = pick_tone(screen_pattern);
		end
		if (cmd[`BIR_CMD_HOST_START])
		begin
			next_s.host_req = 1'b1;
			next_s.host_tone = pick_tone(cmd[`BIR_CMD_PAT_HI:`BIR_CMD_PAT_LO]);
		end
		if (err_event)
			next_s.err_req = 1'b1;
		if (s.check)
		begin
			want = 1'b1;
			sel = TONE_CONT;
		end
		else if (s.mode == BM_ON && (next_s.host_req || next_s.attr_req || next_s.err_req))
		begin
			want = 1'b1;
			if (next_s.host_req)
				sel = next_s.host_tone;
			else if (next_s.attr_req)
				sel = next_s.attr_tone;
		end
		else if (s.mode == BM_ERR_ON)
			want = next_s.err_req;
		else
			want = 1'b0;
		// intermittent tones: on and off halves each last one interval
		interval = (sel == TONE_SHORT) ? SHORT_CYC : LONG_CYC;
		if (!want || !s.active || sel != s.tone)
		begin
			next_s.tone_cnt = '0;
			next_s.phase = 1'b1;
		end
		else if (sel != TONE_CONT && s.tone_cnt == interval - 32'h1)
		begin
			next_s.tone_cnt = '0;
			next_s.phase = !s.phase;
		end
		else if (sel != TONE_CONT)
			next_s.tone_cnt = s.tone_cnt + 32'h1;
		next_s.active = want;
		next_s.tone = sel;
		next_s.buzzer = want && (sel == TONE_CONT || next_s.phase);
		// value writes to the screen word are not activity and do not wake
		idle_limit = (s.idle == IT_1HOUR) ? IDLE_LONG_CYC : IDLE_SHORT_CYC;
		restore = touch_press || touch_stop_press || screen_change || cmd[`BIR_CMD_SCREEN];
		restart = restore || cmd[`BIR_CMD_IDLE_SEL];
		if (restart || s.idle == IT_NONE || !s.disp_on)
			next_s.idle_cnt = '0;
		else if (s.idle_cnt == idle_limit - 40'h1)
		begin
			next_s.idle_cnt = '0;
			next_s.disp_on = 1'b0;
			next_s.bl_on = !COLOUR_MODEL;
		end
		else
			next_s.idle_cnt = s.idle_cnt + 40'h1;
		if (restore)
		begin
			next_s.disp_on = 1'b1;
			next_s.bl_on = 1'b1;
		end
		// pop-up and hard copy share one memory
		next_s.refused = next_s.refused || (cmd[`BIR_CMD_PRINT] && popup_active);
		next_s.print_go = cmd[`BIR_CMD_PRINT] && !popup_active;
		if (s.wb_valid && wb_ready && s.wb_idx == IW'(TABLE_DEPTH - 1))
		begin
			next_s.wb_valid = 1'b0;
			next_s.wb_busy = 1'b0;
		end
		else if (s.wb_valid && wb_ready)
		begin
			next_s.wb_idx = s.wb_idx + IW'(1);
			next_s.wb_data = s.table_mem[s.wb_idx + IW'(1)];
		end
		start_wb = (term_restart || run_entry) && s.resume;
		next_s.redisplay = cmd[`BIR_CMD_SCREEN] || start_wb;
		if (start_wb)
		begin
			next_s.wb_busy = 1'b1;
			next_s.wb_valid = 1'b1;
			next_s.wb_idx = '0;
			next_s.wb_data = s.table_mem[0];
		end
		// without resume nothing is retained; initialize clears always
		clear_tbl = cmd[`BIR_CMD_INIT_TABLE] || ((term_restart || run_entry) && !s.resume);
		if (clear_tbl)
			next_s.table_mem = '0;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s <= '0;
			s.idle <= IT_NONE;
			s.resume <= `BIR_RESUME_RST;
			s.disp_on <= 1'b1;
			s.bl_on <= 1'b1;
			s.rsp.awready <= 1'b1;
			s.rsp.wready <= 1'b1;
			s.rsp.arready <= 1'b1;
		end
		else
			s <= next_s;
	end
	assign axi_rsp = s.rsp;
	assign buzzer = s.buzzer;
	assign display_on = s.disp_on;
	assign backlight_on = s.bl_on;
	assign redisplay_req = s.redisplay;
	assign print_start = s.print_go;
	assign wb_valid = s.wb_valid;
	assign wb_index = s.wb_idx;
	assign wb_data = s.wb_data;
endmodule
`default_nettype wire

// ===== testbench/bir_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module bir_host_model (
	input wire logic aclk,
	input wire logic wb_valid,
	input wire logic [31:0] wb_data,
	output logic wb_ready,
	output logic [31:0] last_word
);
	logic [1:0] cnt = 2'h0;
	// ready only half the time, so the hold of a pending word is exercised
	assign wb_ready = cnt[1];
	always_ff @(posedge aclk)
	begin
		cnt <= cnt + 2'h1;
		if (wb_valid && wb_ready)
			last_word <= wb_data;
	end
endmodule
`default_nettype wire

// ===== testbench/bir_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
module bir_chk
	import bir_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire bir_axi_req_type axi_req,
	input wire bir_axi_rsp_type axi_rsp,
	input wire logic touch_press,
	input wire logic popup_active,
	input wire logic buzzer,
	input wire logic display_on,
	input wire logic backlight_on,
	input wire logic print_start,
	input wire logic wb_valid,
	input wire logic wb_ready,
	input wire logic [31:0] wb_data
);
	default clocking @(posedge aclk); endclocking
	sequence s_wake;
		##[1:4] display_on;
	endsequence
	AST_WAKE: assert property (disable iff (!aresetn) touch_press |-> s_wake) else $error("no wake");
	AST_NOPRT: assert property (disable iff (!aresetn) popup_active && $past(popup_active) |-> !print_start)
		else $error("print in popup");
	AST_BLIGHT: assert property (disable iff (!aresetn) backlight_on == display_on) else $error("backlight");
	AST_WBHOLD: assert property (disable iff (!aresetn) wb_valid && !wb_ready |=> wb_valid && $stable(wb_data))
		else $error("wb hold");
	AST_BHOLD: assert property (disable iff (!aresetn) axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
		else $error("b hold");
	AST_RHOLD: assert property (disable iff (!aresetn) axi_rsp.rvalid && !axi_req.rready |=> $stable(axi_rsp.rdata))
		else $error("r hold");
	AST_RSTQ: assert property (!aresetn |=> !buzzer && !wb_valid && !print_start) else $error("rst out");
	AST_RSTR: assert property (!aresetn |=> !axi_rsp.bvalid && !axi_rsp.rvalid) else $error("rst rsp");
endmodule
bind bir_buzzer_idle_resume bir_chk u_chk (.aclk, .aresetn, .axi_req, .axi_rsp, .touch_press, .popup_active,
	.buzzer, .display_on, .backlight_on, .print_start, .wb_valid, .wb_ready, .wb_data);
`default_nettype wire

// ===== testbench/tb_bir_buzzer_idle_resume.sv
`timescale 1ns/10ps
`default_nettype none
`include "bir_params.svh"
module tb_bir_buzzer_idle_resume
	import bir_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, err = 1'b0, touch = 1'b0, pop = 1'b0, rst2 = 1'b0;
	logic buzzer, disp, bl, prt, wbv, wbr;
	logic sc = 1'b0, sa = 1'b0, ts = 1'b0, run = 1'b0;
	logic [2:0] sp = 3'h0;
	logic [31:0] wbd, last, d;
	logic [1:0] r;
	logic [2:0] pats [3] = '{3'h7, 3'h2, 3'h4};
	int n_mismatch = 0, num_checks = 0;
	bir_axi_req_type rq = '0;
	bir_axi_rsp_type rs;
	initial forever #2 aclk = ~aclk;
	bir_buzzer_idle_resume #(.SHORT_CYC(32'h8), .LONG_CYC(32'h10), .IDLE_SHORT_CYC(40'h28), .IDLE_LONG_CYC(40'h50))
		u_dut (.aclk, .aresetn, .axi_req(rq), .axi_rsp(rs), .err_event(err), .screen_change(sc),
		.screen_buzz_attr(sa), .screen_pattern(sp), .touch_press(touch), .touch_stop_press(ts),
		.popup_active(pop), .term_restart(rst2), .run_entry(run), .wb_ready(wbr), .buzzer, .display_on(disp),
		.backlight_on(bl), .redisplay_req(), .print_start(prt), .wb_valid(wbv), .wb_index(), .wb_data(wbd));
	bir_host_model u_host (.aclk, .wb_valid(wbv), .wb_data(wbd), .wb_ready(wbr), .last_word(last));
	function automatic logic [31:0] ctl(bir_buzz_mode_type m, bir_idle_type t, logic rb);
		return {27'h0, rb, t, m};
	endfunction
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		rq <= '{awaddr: a, awvalid: 1'b1, wdata: v, wstrb: 4'hF, wvalid: 1'b1, bready: 1'b1, default: '0};
		repeat (200)
		begin
			@(posedge aclk);
			if (rs.awready)
				rq.awvalid <= 1'b0;
			if (rs.wready)
				rq.wvalid <= 1'b0;
			if (rs.bvalid)
			begin
				rq.bready <= 1'b0;
				return;
			end
		end
		n_mismatch++;
		close_out();
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		rq <= '{araddr: a, arvalid: 1'b1, rready: 1'b1, default: '0};
		repeat (200)
		begin
			@(posedge aclk);
			if (rs.arready)
				rq.arvalid <= 1'b0;
			if (rs.rvalid)
			begin
				rq.rready <= 1'b0;
				d = rs.rdata;
				r = rs.rresp;
				return;
			end
		end
		n_mismatch++;
		close_out();
	endtask
	task automatic await(ref logic s, input logic v, input string nm);
		for (int i = 0; i < 100 && s !== v; i++)
			@(posedge aclk);
		chk(nm, 32'(s), 32'(v));
	endtask
	// count of high cycles over a window tells continuous from intermittent
	task automatic hi_cnt(input int n, input int e, input string nm);
		int c = 0;
		repeat (n)
		begin
			@(posedge aclk);
			c += 32'(buzzer);
		end
		chk(nm, 32'(c), 32'(e));
	endtask
	initial
	begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		wr(`BIR_OFF_CTRL, ctl(BM_ON, IT_NONE, 1'b0));
		foreach (pats[k])
		begin
			wr(`BIR_OFF_CMD, {25'h0, pats[k], 4'h8});
			await(buzzer, 1'b1, "start");
			hi_cnt(64, k == 0 ? 64 : 32, "tone");
			wr(`BIR_OFF_CMD, 32'h80);
			await(buzzer, 1'b0, "stop");
		end
		sc <= 1'b1;
		sa <= 1'b1;
		sp <= 3'h1;
		@(posedge aclk);
		sc <= 1'b0;
		await(buzzer, 1'b1, "attr");
		hi_cnt(16, 16, "attrtone");
		ts <= 1'b1;
		@(posedge aclk);
		ts <= 1'b0;
		await(buzzer, 1'b0, "bstop");
		wr(`BIR_OFF_CTRL, ctl(BM_ERR_ON, IT_NONE, 1'b0));
		wr(`BIR_OFF_CMD, 32'h18);
		hi_cnt(20, 0, "erronly");
		err <= 1'b1;
		@(posedge aclk);
		err <= 1'b0;
		await(buzzer, 1'b1, "err");
		wr(`BIR_OFF_CTRL, ctl(BM_OFF, IT_10MIN, 1'b0));
		await(buzzer, 1'b0, "off");
		await(disp, 1'b0, "blank");
		chk("bl", 32'(bl), 32'h0);
		touch <= 1'b1;
		@(posedge aclk);
		touch <= 1'b0;
		await(disp, 1'b1, "wake");
		pop <= 1'b1;
		wr(`BIR_OFF_CMD, 32'h400);
		rd(`BIR_OFF_STATUS);
		chk("refuse", 32'(d[`BIR_ST_REFUSED]), 32'h1);
		pop <= 1'b0;
		rd(8'hFC);
		chk("unmapped", 32'(r), 32'(`BIR_RESP_SLVERR));
		wr(8'h7C, 32'hC3C3A5A5);
		wr(`BIR_OFF_CTRL, ctl(BM_OFF, IT_NONE, 1'b1));
		rst2 <= 1'b1;
		@(posedge aclk);
		rst2 <= 1'b0;
		for (int i = 0; i < 300 && last !== 32'hC3C3A5A5; i++)
			@(posedge aclk);
		chk("wback", last, 32'hC3C3A5A5);
		wr(`BIR_OFF_CMD, 32'h200);
		rd(8'h7C);
		chk("init", d, 32'h0);
		wr(8'h7C, 32'h5A5A5A5A);
		wr(`BIR_OFF_CTRL, ctl(BM_OFF, IT_NONE, 1'b0));
		run <= 1'b1;
		@(posedge aclk);
		run <= 1'b0;
		rd(8'h7C);
		chk("runclr", d, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
